// ---- hw/rpts_regs.svh ----
// Constants for the receive SOP timestamp block and its client end
`ifndef RPTS_REGS_SVH
`define RPTS_REGS_SVH

`define RPTS_TIME_W      80
`define RPTS_LANE_W      5
`define RPTS_LANES       20
`define RPTS_FILL_W      7
`define RPTS_SEGS        4

// Normal clock layout field positions
`define RPTS_NC_SEC_MSB  79
`define RPTS_NC_SEC_LSB  32
`define RPTS_NC_NS_MSB   31
`define RPTS_NC_NS_LSB   0

// Transparent clock layout field positions
`define RPTS_TC_SIGN     63
`define RPTS_TC_NS_MSB   62
`define RPTS_TC_NS_LSB   16
`define RPTS_TC_FR_MSB   15
`define RPTS_TC_FR_LSB   0

// Reset values and limits
`define RPTS_TS_RST      80'h0000_0000_0000_0000_0000
`define RPTS_LANE_RST    5'h00
`define RPTS_LANE_LAST   5'h13
`define RPTS_FILL_RST    7'h00
`define RPTS_FILL_MAX    7'h7f
`define RPTS_SOP_RST     4'h0

`endif

// ---- hw/rpts_pkg.sv ----
// Types shared by both ends of the receive SOP timestamp link
`include "rpts_regs.svh"

package rpts_pkg;

    typedef logic [`RPTS_TIME_W-1:0]                     rpts_time_t;
    typedef logic [`RPTS_LANE_W-1:0]                     rpts_lane_t;
    typedef logic [`RPTS_FILL_W-1:0]                     rpts_fill_t;
    typedef logic [`RPTS_LANES-1:0][`RPTS_FILL_W-1:0]    rpts_fill_arr_t;
    typedef logic [`RPTS_SEGS-1:0]                       rpts_sop_t;

    // Capture tracking state of the device end
    typedef enum logic [1:0] {
        RPTS_IDLE  = 2'b01,
        RPTS_ARMED = 2'b10
    } rpts_state_t;

    // True when any segment of the client bus carries a start of packet
    function automatic logic rpts_any_sop(input rpts_sop_t sop);
        rpts_any_sop = |sop;
    endfunction

endpackage

// ---- hw/rpts_link_if.sv ----
// Link between the timestamp device end and the client PTP end
`timescale 1ns/1ps
`include "rpts_regs.svh"

interface rpts_link_if;
    rpts_pkg::rpts_sop_t      sop;
    rpts_pkg::rpts_time_t     tstamp;
    rpts_pkg::rpts_lane_t     pcslane;
    rpts_pkg::rpts_fill_arr_t fill;

    modport dev (output sop, output tstamp, output pcslane, output fill);
    modport client (input sop, input tstamp, input pcslane, input fill);
endinterface

// ---- hw/rpts_lane_fill.sv ----
// Fill level counter for one lane alignment buffer
`timescale 1ns/1ps
`include "rpts_regs.svh"

module rpts_lane_fill (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output rpts_pkg::rpts_fill_t   fill_o
);
    rpts_pkg::rpts_fill_t fill;
    rpts_pkg::rpts_fill_t next_fill;

    // Count words held, one per SerDes cycle, saturating at both ends
    always_comb begin
        next_fill = fill;
        if (wr_i && !rd_i && fill != `RPTS_FILL_MAX) begin
            next_fill = fill + 7'h01;
        end else if (rd_i && !wr_i && fill != `RPTS_FILL_RST) begin
            next_fill = fill - 7'h01;
        end
    end

    // Fill register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            fill <= `RPTS_FILL_RST;
        end else begin
            fill <= next_fill;
        end
    end

    assign fill_o = fill;
endmodule

// ---- hw/rpts_dev.sv ----
// Device end: captures SOP time at the capture plane, reports it at client SOP
`timescale 1ns/1ps
`include "rpts_regs.svh"

module rpts_dev (
    input  wire logic                  clk_i,
    input  wire logic                  reset_i,
    // System time, driven on this same lane 0 clock by the time source
    input  rpts_pkg::rpts_time_t       sys_time_i,
    // Start of packet crossing the capture plane, with its PCS lane
    input  wire logic                  capture_i,
    input  rpts_pkg::rpts_lane_t       capture_lane_i,
    // Segment SOP flags of the receive pipe, one cycle before the client bus
    input  rpts_pkg::rpts_sop_t        seg_sop_i,
    // Alignment buffer write and read strobes, one bit per PCS lane
    input  wire logic [`RPTS_LANES-1:0] aligner_wr_i,
    input  wire logic [`RPTS_LANES-1:0] aligner_rd_i,
    // Set when a capture was replaced before its SOP reached the client
    output logic                       capture_overrun_o,
    rpts_link_if.dev                   link
);
    // Capture tracking state
    rpts_pkg::rpts_state_t state;
    rpts_pkg::rpts_state_t next_state;

    // Pending capture waiting for its SOP on the client bus
    rpts_pkg::rpts_time_t  pend_ts;
    rpts_pkg::rpts_time_t  next_pend_ts;
    rpts_pkg::rpts_lane_t  pend_lane;
    rpts_pkg::rpts_lane_t  next_pend_lane;

    // Values shown to the client
    rpts_pkg::rpts_sop_t   sop;
    rpts_pkg::rpts_sop_t   next_sop;
    rpts_pkg::rpts_time_t  tstamp;
    rpts_pkg::rpts_time_t  next_tstamp;
    rpts_pkg::rpts_lane_t  pcslane;
    rpts_pkg::rpts_lane_t  next_pcslane;
    logic                  overrun;
    logic                  next_overrun;

    logic                  sop_now;
    logic                  have_capture;

    assign sop_now      = rpts_pkg::rpts_any_sop(seg_sop_i);
    assign have_capture = (state == rpts_pkg::RPTS_ARMED);

    // Capture tracking: arm on a capture-plane event, disarm when its SOP is shown
    always_comb begin
        next_state     = state;
        next_pend_ts   = pend_ts;
        next_pend_lane = pend_lane;
        next_overrun   = overrun;
        case (state)
            rpts_pkg::RPTS_IDLE: begin
                if (capture_i && !sop_now) begin
                    next_state = rpts_pkg::RPTS_ARMED;
                end
            end
            rpts_pkg::RPTS_ARMED: begin
                if (sop_now && !capture_i) begin
                    next_state = rpts_pkg::RPTS_IDLE;
                end else if (capture_i && !sop_now) begin
                    next_overrun = 1'b1;    // Older capture lost, sticky until reset
                end
            end
            default: begin
                next_state = rpts_pkg::RPTS_IDLE;
            end
        endcase
        // Time is taken as the SOP passes the capture plane, unchanged in layout
        if (capture_i) begin
            next_pend_ts   = sys_time_i;
            next_pend_lane = capture_lane_i;
        end
    end

    // Capture tracking registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state     <= rpts_pkg::RPTS_IDLE;
            pend_ts   <= `RPTS_TS_RST;
            pend_lane <= `RPTS_LANE_RST;
            overrun   <= 1'b0;
        end else begin
            state     <= next_state;
            pend_ts   <= next_pend_ts;
            pend_lane <= next_pend_lane;
            overrun   <= next_overrun;
        end
    end

    // Client output: SOP flags pass one register, timestamp loads with them
    always_comb begin
        next_sop     = seg_sop_i;
        next_tstamp  = tstamp;
        next_pcslane = pcslane;
        if (sop_now) begin
            if (capture_i && !have_capture) begin
                // SOP crossed the plane in this very cycle: take time directly
                next_tstamp  = sys_time_i;
                next_pcslane = capture_lane_i;
            end else begin
                next_tstamp  = pend_ts;
                next_pcslane = pend_lane;
            end
        end
        // Without a new SOP the last timestamp and lane stay in place
    end

    // Client output registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sop     <= `RPTS_SOP_RST;
            tstamp  <= `RPTS_TS_RST;
            pcslane <= `RPTS_LANE_RST;
        end else begin
            sop     <= next_sop;
            tstamp  <= next_tstamp;
            pcslane <= next_pcslane;
        end
    end

    // One fill counter per PCS lane, lanes 0 to 8 and 9 to 19 alike
    genvar g;
    generate
        for (g = 0; g < `RPTS_LANES; g = g + 1) begin : g_lane
            rpts_lane_fill u_fill (
                .clk_i   (clk_i),
                .reset_i (reset_i),
                .wr_i    (aligner_wr_i[g]),
                .rd_i    (aligner_rd_i[g]),
                .fill_o  (link.fill[g])
            );
        end
    endgenerate

    // Link drive, all from registers
    assign link.sop       = sop;
    assign link.tstamp    = tstamp;
    assign link.pcslane   = pcslane;
    assign capture_overrun_o = overrun;
endmodule

// ---- hw/rpts_client.sv ----
// Client end: samples timestamp and lane at SOP and decodes the time fields
`timescale 1ns/1ps
`include "rpts_regs.svh"

module rpts_client (
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    // Selects transparent clock interpretation of the time fields
    input  wire logic               tc_mode_i,
    rpts_link_if.client             link,
    output logic                    ts_valid_o,
    output rpts_pkg::rpts_time_t    ts_o,
    output rpts_pkg::rpts_lane_t    lane_o,
    output rpts_pkg::rpts_fill_t    lane_fill_o,
    output logic [47:0]             sec_o,
    output logic [46:0]             ns_o,
    output logic [15:0]             frac_ns_o,
    output logic                    sign_o
);
    logic                  next_ts_valid;
    rpts_pkg::rpts_time_t  next_ts;
    rpts_pkg::rpts_lane_t  next_lane;
    rpts_pkg::rpts_fill_t  next_lane_fill;
    logic [47:0]           next_sec;
    logic [46:0]           next_ns;
    logic [15:0]           next_frac;
    logic                  next_sign;

    // Sample in the SOP cycle and split the time by clock mode
    always_comb begin
        next_ts_valid  = rpts_pkg::rpts_any_sop(link.sop);
        next_ts        = ts_o;
        next_lane      = lane_o;
        next_lane_fill = lane_fill_o;
        next_sec       = sec_o;
        next_ns        = ns_o;
        next_frac      = frac_ns_o;
        next_sign      = sign_o;
        if (next_ts_valid) begin
            next_ts   = link.tstamp;
            next_lane = link.pcslane;
            // Fill of the SOP's lane, for skew correction by client software
            if (link.pcslane <= `RPTS_LANE_LAST) begin
                next_lane_fill = link.fill[link.pcslane];
            end else begin
                next_lane_fill = `RPTS_FILL_RST;
            end
            if (tc_mode_i) begin
                next_sec  = 48'h0000_0000_0000;
                next_sign = link.tstamp[`RPTS_TC_SIGN];
                next_ns   = link.tstamp[`RPTS_TC_NS_MSB:`RPTS_TC_NS_LSB];
                next_frac = link.tstamp[`RPTS_TC_FR_MSB:`RPTS_TC_FR_LSB];
            end else begin
                next_sec  = link.tstamp[`RPTS_NC_SEC_MSB:`RPTS_NC_SEC_LSB];
                next_ns   = {15'h0000, link.tstamp[`RPTS_NC_NS_MSB:`RPTS_NC_NS_LSB]};
                next_frac = 16'h0000;
                next_sign = 1'b0;
            end
        end
    end

    // Output registers
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ts_valid_o  <= 1'b0;
            ts_o        <= `RPTS_TS_RST;
            lane_o      <= `RPTS_LANE_RST;
            lane_fill_o <= `RPTS_FILL_RST;
            sec_o       <= 48'h0000_0000_0000;
            ns_o        <= 47'h0000_0000_0000;
            frac_ns_o   <= 16'h0000;
            sign_o      <= 1'b0;
        end else begin
            ts_valid_o  <= next_ts_valid;
            ts_o        <= next_ts;
            lane_o      <= next_lane;
            lane_fill_o <= next_lane_fill;
            sec_o       <= next_sec;
            ns_o        <= next_ns;
            frac_ns_o   <= next_frac;
            sign_o      <= next_sign;
        end
    end
endmodule

// ---- sim/rpts_link_monitor.sv ----
// Concurrent checks on the link between the timestamp device end and client end
`timescale 1ns/1ps
`include "rpts_regs.svh"

module rpts_link_monitor (
    input wire logic                clk_i,
    input wire logic                reset_i,
    input rpts_pkg::rpts_sop_t      sop,
    input rpts_pkg::rpts_time_t     tstamp,
    input rpts_pkg::rpts_lane_t     pcslane,
    input rpts_pkg::rpts_fill_arr_t fill
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    // Three cycles in a row with no SOP on any segment
    sequence s_quiet;
        (sop == '0) [*3];
    endsequence

    // Timestamp and lane move only in a cycle that carries an SOP
    a_ts_hold_idle: assert property (sop == '0 |-> $stable(tstamp))
        else $error("timestamp changed without SOP");
    a_lane_hold_idle: assert property (sop == '0 |-> $stable(pcslane))
        else $error("lane changed without SOP");
    a_ts_move_sop: assert property ($changed(tstamp) |-> sop != '0)
        else $error("timestamp update outside SOP cycle");
    a_lane_move_sop: assert property ($changed(pcslane) |-> sop != '0)
        else $error("lane update outside SOP cycle");
    a_quiet_keep: assert property (s_quiet |-> tstamp == $past(tstamp, 2)
        && pcslane == $past(pcslane, 2)) else $error("values drifted between SOPs");
    a_lane_in_range: assert property (pcslane <= `RPTS_LANE_LAST)
        else $error("lane index beyond last PCS lane");

    // Each fill level moves by one count at most per cycle and never wraps
    for (genvar g = 0; g < `RPTS_LANES; g++) begin : g_fill
        if (g < 9) begin : g_lo
            a_fill_step_low: assert property ($stable(fill[g])
                || fill[g] == $past(fill[g]) + 8'h01 || fill[g] + 8'h01 == $past(fill[g]))
                else $error("low lane fill jumped");
        end else begin : g_hi
            a_fill_step_high: assert property ($stable(fill[g])
                || fill[g] == $past(fill[g]) + 8'h01 || fill[g] + 8'h01 == $past(fill[g]))
                else $error("high lane fill jumped");
        end
    end
endmodule

// ---- sim/rpts_bench.sv ----
// Testbench joining device and client ends of the SOP timestamp link
`timescale 1ns/1ps
`include "rpts_regs.svh"

module rpts_bench;
    logic                 clk_i   = 1'b0;
    logic                 reset_i = 1'b1;
    logic                 capture = 1'b0;
    logic                 tc      = 1'b0;
    rpts_pkg::rpts_time_t systime = '0;
    rpts_pkg::rpts_lane_t cap_lane = '0;
    rpts_pkg::rpts_sop_t  seg_sop = '0;
    logic [19:0]          wr      = '0;
    logic [19:0]          rd      = '0;
    logic                 overrun, ts_valid, sign;
    rpts_pkg::rpts_time_t ts;
    rpts_pkg::rpts_lane_t lane;
    rpts_pkg::rpts_fill_t lane_fill;
    logic [47:0]          sec;
    logic [46:0]          ns;
    logic [15:0]          frac;
    int                   failures = 0;
    int                   cmp_count = 0;

    // Clock at 250 MHz
    always #2 clk_i = ~clk_i;

    rpts_link_if i_rpts_link_if ();
    rpts_dev i_rpts_dev (.clk_i(clk_i), .reset_i(reset_i), .sys_time_i(systime),
        .capture_i(capture), .capture_lane_i(cap_lane), .seg_sop_i(seg_sop),
        .aligner_wr_i(wr), .aligner_rd_i(rd), .capture_overrun_o(overrun),
        .link(i_rpts_link_if));
    rpts_client i_rpts_client (.clk_i(clk_i), .reset_i(reset_i), .tc_mode_i(tc),
        .link(i_rpts_link_if), .ts_valid_o(ts_valid), .ts_o(ts), .lane_o(lane),
        .lane_fill_o(lane_fill), .sec_o(sec), .ns_o(ns), .frac_ns_o(frac), .sign_o(sign));
    rpts_link_monitor i_rpts_link_monitor (.clk_i(clk_i), .reset_i(reset_i),
        .sop(i_rpts_link_if.sop), .tstamp(i_rpts_link_if.tstamp),
        .pcslane(i_rpts_link_if.pcslane), .fill(i_rpts_link_if.fill));

    // Compare one value and count it
    task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Print the counts and the verdict, then stop
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One capture-plane event with its time and lane
    task automatic cap(input rpts_pkg::rpts_time_t t, input rpts_pkg::rpts_lane_t l);
        @(posedge clk_i);
        capture <= 1'b1;
        systime <= t;
        cap_lane <= l;
        @(posedge clk_i);
        capture <= 1'b0;
        systime <= ~t;
    endtask

    // SOP on segments f, optionally with a capture in the same cycle, then checks
    task automatic pkt(input logic c, input rpts_pkg::rpts_sop_t f,
        input rpts_pkg::rpts_time_t t, input rpts_pkg::rpts_lane_t l,
        input rpts_pkg::rpts_fill_t fe, input logic m);
        @(posedge clk_i);
        capture <= c;
        systime <= c ? t : ~t;
        cap_lane <= c ? l : ~l;
        seg_sop <= f;
        tc <= m;
        @(posedge clk_i);
        capture <= 1'b0;
        seg_sop <= '0;
        #1;
        chk("link sop", f, i_rpts_link_if.sop);
        chk("link time", t, i_rpts_link_if.tstamp);
        chk("link lane", l, i_rpts_link_if.pcslane);
        @(posedge clk_i);
        #1;
        chk("valid", 1'b1, ts_valid);
        chk("time", t, ts);
        chk("lane", l, lane);
        chk("lane fill", fe, lane_fill);
        chk("seconds", m ? '0 : t[79:32], sec);
        chk("nanoseconds", m ? t[62:16] : t[31:0], ns);
        chk("fraction", m ? t[15:0] : 16'h0000, frac);
        chk("sign", m & t[63], sign);
        @(posedge clk_i);
        #1;
        chk("valid pulse", 1'b0, ts_valid);
        chk("held time", t, i_rpts_link_if.tstamp);
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        // Lane k gets k+1 writes, then one cycle of write and read together and one cycle of read alone
        for (int c = 0; c < 20; c++) begin
            @(posedge clk_i);
            wr <= 20'hf_ffff << c;
        end
        @(posedge clk_i);
        wr <= '0;
        @(posedge clk_i);
        #1;
        for (int k = 0; k < 20; k++) chk("fill", k + 1, i_rpts_link_if.fill[k]);
        @(posedge clk_i);
        wr <= '1;
        rd <= '1;
        @(posedge clk_i);
        wr <= '0;
        @(posedge clk_i);
        rd <= '0;
        // Captured lane 19 shown at a later SOP, then same-cycle capture per segment
        cap(80'h8765_4321_0fed_cba9_8765, 5'h13);
        pkt(1'b0, 4'h8, 80'h8765_4321_0fed_cba9_8765, 5'h13, 7'h13, 1'b0);
        for (int s = 0; s < 4; s++) pkt(1'b1, 4'h1 << s, 80'h0000_9abc_def0_1234_5678 + s,
            5'(s * 6), 7'(s * 6), s[0]);
        chk("no overrun", 1'b0, overrun);
        // Two captures before one SOP: the newer one belongs to the packet
        cap(80'h0000_1111_2222_3333_4444, 5'h03);
        cap(80'h0000_5555_6666_7777_8888, 5'h05);
        pkt(1'b0, 4'h3, 80'h0000_5555_6666_7777_8888, 5'h05, 7'h05, 1'b0);
        chk("overrun", 1'b1, overrun);
        // Fill saturates at full and at empty
        @(posedge clk_i);
        wr <= 20'h0_0010;
        repeat (130) @(posedge clk_i);
        wr <= '0;
        @(posedge clk_i);
        #1;
        chk("fill full", 7'h7f, i_rpts_link_if.fill[4]);
        @(posedge clk_i);
        rd <= '1;
        repeat (130) @(posedge clk_i);
        rd <= '0;
        @(posedge clk_i);
        #1;
        for (int k = 0; k < 20; k++) chk("fill empty", '0, i_rpts_link_if.fill[k]);
        results();
    end

    // Cut a hang short
    initial begin
        #100000;
        failures++;
        results();
    end
endmodule
